// file: psn_cfg.svh
// Constants of the status and non-volatile command block: command codes,
// transfer kinds, bit positions, reset values and timing counts.
// Assumes it is included by its bare name wherever these are needed.
`ifndef PSN_CFG_SVH
`define PSN_CFG_SVH

// Command codes
`define PSN_CODE_OPERATION  8'h01
`define PSN_CODE_ONOFF_CFG  8'h02
`define PSN_CODE_CLEAR      8'h03
`define PSN_CODE_STORE      8'h11
`define PSN_CODE_RESTORE    8'h12
`define PSN_CODE_STAT_LOW   8'h78
`define PSN_CODE_STAT_FULL  8'h79
`define PSN_CODE_SCRATCH    8'hD0

// Transfer kinds reported by the bus front end
`define PSN_KIND_SEND       2'h0
`define PSN_KIND_WR_BYTE    2'h1
`define PSN_KIND_RD_BYTE    2'h2
`define PSN_KIND_RD_WORD    2'h3

// Indices of the synchronised pin inputs
`define PSN_IN_OV           0
`define PSN_IN_OC           1
`define PSN_IN_UV           2
`define PSN_IN_OT           3
`define PSN_IN_WARN_VOUT    4
`define PSN_IN_WARN_IOUT    5
`define PSN_IN_WARN_VIN     6
`define PSN_IN_POWER_OK     7
`define PSN_IN_OUT_ON       8
`define PSN_IN_EN           9
`define PSN_IN_W            10

// Indices of the latched flags
`define PSN_FLG_OV          0
`define PSN_FLG_OC          1
`define PSN_FLG_UV          2
`define PSN_FLG_OT          3
`define PSN_FLG_CML         4
`define PSN_FLG_VOUT        5
`define PSN_FLG_IOUT        6
`define PSN_FLG_INPUT       7
`define PSN_FLG_W           8

// Configuration and operation bit positions
`define PSN_CFG_ONOFF_BIT   3
`define PSN_CFG_PIN_BIT     2
`define PSN_CFG_FIXED_ONES  8'h13
`define PSN_OPER_ONOFF_BIT  7
`define PSN_SCRATCH_W       6

// Reset values of the operating registers and the factory store
`define PSN_RST_ONOFF_BIT   1'b0
`define PSN_RST_PIN_BIT     1'b1
`define PSN_RST_ON_OFF      1'b0
`define PSN_RST_SCRATCH     6'h00

// Store layout and copy timing
`define PSN_NVM_WORDS       2
`define PSN_NVM_IDX_CFG     1'b0
`define PSN_NVM_IDX_SCR     1'b1
`define PSN_MCLK_NS         8
`define PSN_NVM_STEP_NS     32
`define PSN_NVM_STEP_CYC    ((`PSN_NVM_STEP_NS + `PSN_MCLK_NS - 1) / `PSN_MCLK_NS)

`endif

// file: psn_pkg.sv
// Types of the status and non-volatile command block.
// Assumes psn_cfg.svh is on the include path.
`include "psn_cfg.svh"

package psn_pkg;

    // Copy sequencer states
    typedef enum logic [1:0]
    {
        NV_IDLE,
        NV_STORE,
        NV_RESTORE
    } psn_nv_state_t;

    // Whole state of the top module
    typedef struct packed
    {
        logic [`PSN_IN_W-1:0]           s1;
        logic [`PSN_IN_W-1:0]           s2;
        logic [`PSN_IN_W-1:0]           s3;
        logic [`PSN_IN_W-1:0]           filt;
        logic                           on_off;
        logic                           act_on_onoff_bit;
        logic                           act_on_pin_switch;
        logic [`PSN_SCRATCH_W-1:0]      user_scratch_bits;
        logic [`PSN_NVM_WORDS-1:0][7:0] nvm;
        psn_nv_state_t                  st;
        logic                           idx;
        logic [2:0]                     step_cnt;
        logic                           conv_en;
        logic                           clear;
        logic                           cml_pulse;
        logic                           rsp_valid;
        logic [15:0]                    rsp_data;
        logic                           busy;
        logic                           alert;
        logic                           alert_lvl;
    } psn_top_t;

    // Whole state of the flag bank
    typedef struct packed
    {
        logic [`PSN_FLG_W-1:0] flags;
    } psn_flag_t;

endpackage

// file: psn_flag_if.sv
// Carrier between the command logic and the latched flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "psn_cfg.svh"

interface psn_flag_if;
    logic [`PSN_FLG_W-1:0] cond;
    logic                  clear;
    logic [`PSN_FLG_W-1:0] flags;

    modport ctrl
    (
        output cond,
        output clear,
        input  flags
    );

    modport bank
    (
        input  cond,
        input  clear,
        output flags
    );
endinterface

// file: psn_flags.sv
// Latched fault flag bank.
// Assumes conditions arrive already synchronised to MCLK.
`timescale 1ns/1ps
`include "psn_cfg.svh"

module psn_flags
(
    // Clock and reset
    input  wire logic MCLK,
    input  wire logic RST_N,
    // Conditions, clear and flags
    psn_flag_if.bank  fif
);

    psn_pkg::psn_flag_t     f;
    psn_pkg::psn_flag_t     next_f;
    logic [`PSN_FLG_W-1:0]  next_bits;

    // ------------------------------------------------------------
    // Per-flag latch
    // ------------------------------------------------------------
    // A live condition beats the clear, so a persisting fault re-sets
    genvar i;
    generate
        for (i = 0; i < `PSN_FLG_W; i = i + 1)
        begin : g_flag
            assign next_bits[i] = fif.cond[i] | (f.flags[i] & ~fif.clear);
        end
    endgenerate

    // Next state with synchronous reset
    always_comb
    begin
        next_f.flags = next_bits;
        if (!RST_N)
        begin
            next_f = '0;
        end
    end

    // State register
    always_ff @(posedge MCLK)
    begin
        f <= next_f;
    end

    assign fif.flags = f.flags;

endmodule

// file: psn_status_nvm.sv
// Status word, fault flags, alert, custom register and store/restore
// copies for a converter's management command set.
// Assumes a bus front end that decodes each transaction into one command
// pulse with its code, kind and data byte, and reports malformed frames.
`timescale 1ns/1ps
`include "psn_cfg.svh"

module psn_status_nvm
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Decoded command port
    input  wire logic        CMD_VALID,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic [1:0]  CMD_KIND,
    input  wire logic [7:0]  CMD_WDATA,
    input  wire logic        CMD_MALFORMED,
    input  wire logic        ADDR_DONE,
    // Read answer and copy activity
    output logic             RSP_VALID,
    output logic      [15:0] RSP_DATA,
    output logic             NVM_BUSY,
    // Fault and status pins from the analog side
    input  wire logic        OV_FAULT_PIN,
    input  wire logic        OC_FAULT_PIN,
    input  wire logic        UV_FAULT_PIN,
    input  wire logic        OT_FAULT_PIN,
    input  wire logic        VOUT_WARN_PIN,
    input  wire logic        IOUT_WARN_PIN,
    input  wire logic        VIN_WARN_PIN,
    input  wire logic        POWER_OK_PIN,
    input  wire logic        OUTPUT_ON_PIN,
    input  wire logic        ENABLE_PIN,
    // Converter control
    output logic             CONV_ENABLE,
    // Open-drain alert
    output logic             ALERT_O,
    output logic             ALERT_OE
);

    psn_pkg::psn_top_t      s;
    psn_pkg::psn_top_t      next_s;
    logic [`PSN_IN_W-1:0]   pins;
    logic                   en_req;
    logic                   bad_cmd;
    logic [7:0]             stat_lo;
    logic [7:0]             stat_hi;
    logic                   step_done;

    psn_flag_if fif();

    psn_flags u_flags
    (
        .MCLK  (MCLK),
        .RST_N (RST_N),
        .fif   (fif)
    );

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Configuration byte as read back and as stored; unused bits 0, 1 and 4 show 1, bits 5 to 7 show 0
    function automatic logic [7:0] pack_cfg(input logic onoff_bit,
                                            input logic pin_bit);
        logic [7:0] b;
        b = `PSN_CFG_FIXED_ONES;
        b[`PSN_CFG_ONOFF_BIT] = onoff_bit;
        b[`PSN_CFG_PIN_BIT]   = pin_bit;
        return b;
    endfunction

    // Scratch byte as read back and as stored; top bits read zero
    function automatic logic [7:0] pack_scratch(
        input logic [`PSN_SCRATCH_W-1:0] v);
        return {2'b00, v};
    endfunction

    // Pin inputs in their synchroniser order
    assign pins[`PSN_IN_OV]        = OV_FAULT_PIN;
    assign pins[`PSN_IN_OC]        = OC_FAULT_PIN;
    assign pins[`PSN_IN_UV]        = UV_FAULT_PIN;
    assign pins[`PSN_IN_OT]        = OT_FAULT_PIN;
    assign pins[`PSN_IN_WARN_VOUT] = VOUT_WARN_PIN;
    assign pins[`PSN_IN_WARN_IOUT] = IOUT_WARN_PIN;
    assign pins[`PSN_IN_WARN_VIN]  = VIN_WARN_PIN;
    assign pins[`PSN_IN_POWER_OK]  = POWER_OK_PIN;
    assign pins[`PSN_IN_OUT_ON]    = OUTPUT_ON_PIN;
    assign pins[`PSN_IN_EN]        = ENABLE_PIN;

    // ------------------------------------------------------------
    // Flag conditions
    // ------------------------------------------------------------
    // Summary flags take the fault or the warning of their group
    assign fif.cond[`PSN_FLG_OV]    = s.filt[`PSN_IN_OV];
    assign fif.cond[`PSN_FLG_OC]    = s.filt[`PSN_IN_OC];
    assign fif.cond[`PSN_FLG_UV]    = s.filt[`PSN_IN_UV];
    assign fif.cond[`PSN_FLG_OT]    = s.filt[`PSN_IN_OT];
    assign fif.cond[`PSN_FLG_CML]   = s.cml_pulse;
    assign fif.cond[`PSN_FLG_VOUT]  = s.filt[`PSN_IN_OV]
                                    | s.filt[`PSN_IN_WARN_VOUT];
    assign fif.cond[`PSN_FLG_IOUT]  = s.filt[`PSN_IN_OC]
                                    | s.filt[`PSN_IN_WARN_IOUT];
    assign fif.cond[`PSN_FLG_INPUT] = s.filt[`PSN_IN_UV]
                                    | s.filt[`PSN_IN_WARN_VIN];
    assign fif.clear                = s.clear;

    // ------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------
    // Low byte: busy and other tied low, off is raw, the rest latched
    assign stat_lo = {1'b0,
                      ~s.filt[`PSN_IN_OUT_ON],
                      fif.flags[`PSN_FLG_OV],
                      fif.flags[`PSN_FLG_OC],
                      fif.flags[`PSN_FLG_UV],
                      fif.flags[`PSN_FLG_OT],
                      fif.flags[`PSN_FLG_CML],
                      1'b0};

    // High byte: three summaries, raw inverted power-ok, rest zero
    assign stat_hi = {fif.flags[`PSN_FLG_VOUT],
                      fif.flags[`PSN_FLG_IOUT],
                      fif.flags[`PSN_FLG_INPUT],
                      1'b0,
                      ~s.filt[`PSN_IN_POWER_OK],
                      3'b000};

    // Copy step ends when the wait counter has run out
    assign step_done = (s.step_cnt == 3'(`PSN_NVM_STEP_CYC - 1));

    // ------------------------------------------------------------
    // Enable source selection
    // ------------------------------------------------------------
    // Neither source selected means on as soon as the address is known
    always_comb
    begin
        case ({s.act_on_onoff_bit, s.act_on_pin_switch})
            2'b00:   en_req = ADDR_DONE;
            2'b01:   en_req = s.filt[`PSN_IN_EN];
            2'b10:   en_req = s.on_off;
            default: en_req = s.on_off & s.filt[`PSN_IN_EN];
        endcase
    end

    // ------------------------------------------------------------
    // Command check
    // ------------------------------------------------------------
    // Any code or kind the block does not answer counts as a comm fault while no copy runs
    always_comb
    begin
        case (CMD_CODE)
            `PSN_CODE_CLEAR,
            `PSN_CODE_STORE,
            `PSN_CODE_RESTORE:
                bad_cmd = (CMD_KIND != `PSN_KIND_SEND);
            `PSN_CODE_STAT_LOW:
                bad_cmd = (CMD_KIND != `PSN_KIND_RD_BYTE);
            `PSN_CODE_STAT_FULL:
                bad_cmd = (CMD_KIND != `PSN_KIND_RD_WORD);
            `PSN_CODE_OPERATION,
            `PSN_CODE_ONOFF_CFG,
            `PSN_CODE_SCRATCH:
                bad_cmd = (CMD_KIND != `PSN_KIND_RD_BYTE)
                        && (CMD_KIND != `PSN_KIND_WR_BYTE);
            default:
                bad_cmd = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;

        // Three-stage synchroniser; a change counts once stages 2 and 3 agree
        next_s.s1   = pins;
        next_s.s2   = s.s1;
        next_s.s3   = s.s2;
        next_s.filt = (s.s2 & s.s3) | (s.filt & (s.s2 | s.s3));

        // One-cycle pulses drop unless raised below
        next_s.rsp_valid = 1'b0;
        next_s.cml_pulse = 1'b0;
        next_s.clear     = 1'b0;

        // An off-to-on transition of the commanded enable clears flags
        next_s.conv_en = en_req;
        if (en_req && !s.conv_en)
        begin
            next_s.clear = 1'b1;
        end

        // Alert pin pulled low while any flag stands
        next_s.alert     = |fif.flags;
        next_s.alert_lvl = 1'b0;

        case (s.st)
            psn_pkg::NV_IDLE:
            begin
                if (CMD_MALFORMED)
                begin
                    next_s.cml_pulse = 1'b1;
                end
                if (CMD_VALID && bad_cmd)
                begin
                    next_s.cml_pulse = 1'b1;
                end
                else if (CMD_VALID)
                begin
                    case (CMD_CODE)
                        `PSN_CODE_CLEAR:
                        begin
                            next_s.clear = 1'b1;
                        end
                        `PSN_CODE_STORE:
                        begin
                            next_s.st       = psn_pkg::NV_STORE;
                            next_s.idx      = 1'b0;
                            next_s.step_cnt = 3'h0;
                            next_s.busy     = 1'b1;
                        end
                        `PSN_CODE_RESTORE:
                        begin
                            next_s.st       = psn_pkg::NV_RESTORE;
                            next_s.idx      = 1'b0;
                            next_s.step_cnt = 3'h0;
                            next_s.busy     = 1'b1;
                        end
                        `PSN_CODE_STAT_LOW:
                        begin
                            next_s.rsp_valid = 1'b1;
                            next_s.rsp_data  = {8'h00, stat_lo};
                        end
                        `PSN_CODE_STAT_FULL:
                        begin
                            next_s.rsp_valid = 1'b1;
                            next_s.rsp_data  = {stat_hi, stat_lo};
                        end
                        `PSN_CODE_OPERATION:
                        begin
                            if (CMD_KIND == `PSN_KIND_WR_BYTE)
                            begin
                                next_s.on_off =
                                    CMD_WDATA[`PSN_OPER_ONOFF_BIT];
                            end
                            else
                            begin
                                next_s.rsp_valid = 1'b1;
                                next_s.rsp_data  = {8'h00, s.on_off, 7'h00};
                            end
                        end
                        `PSN_CODE_ONOFF_CFG:
                        begin
                            if (CMD_KIND == `PSN_KIND_WR_BYTE)
                            begin
                                next_s.act_on_onoff_bit =
                                    CMD_WDATA[`PSN_CFG_ONOFF_BIT];
                                next_s.act_on_pin_switch =
                                    CMD_WDATA[`PSN_CFG_PIN_BIT];
                            end
                            else
                            begin
                                next_s.rsp_valid = 1'b1;
                                next_s.rsp_data  =
                                    {8'h00, pack_cfg(s.act_on_onoff_bit,
                                                     s.act_on_pin_switch)};
                            end
                        end
                        `PSN_CODE_SCRATCH:
                        begin
                            if (CMD_KIND == `PSN_KIND_WR_BYTE)
                            begin
                                next_s.user_scratch_bits =
                                    CMD_WDATA[`PSN_SCRATCH_W-1:0];
                            end
                            else
                            begin
                                next_s.rsp_valid = 1'b1;
                                next_s.rsp_data  =
                                    {8'h00, pack_scratch(s.user_scratch_bits)};
                            end
                        end
                        default:
                        begin
                            next_s.cml_pulse = 1'b1;
                        end
                    endcase
                end
            end

            // Commands are dropped while copying; the bus sees no answer
            psn_pkg::NV_STORE:
            begin
                next_s.step_cnt = s.step_cnt + 3'h1;
                if (step_done)
                begin
                    next_s.step_cnt = 3'h0;
                    if (s.idx == `PSN_NVM_IDX_CFG)
                    begin
                        next_s.nvm[s.idx] = pack_cfg(s.act_on_onoff_bit,
                                                     s.act_on_pin_switch);
                    end
                    else
                    begin
                        next_s.nvm[s.idx] =
                            pack_scratch(s.user_scratch_bits);
                    end
                    next_s.idx = ~s.idx;
                    if (s.idx == `PSN_NVM_IDX_SCR)
                    begin
                        next_s.st   = psn_pkg::NV_IDLE;
                        next_s.busy = 1'b0;
                    end
                end
            end

            psn_pkg::NV_RESTORE:
            begin
                next_s.step_cnt = s.step_cnt + 3'h1;
                if (step_done)
                begin
                    next_s.step_cnt = 3'h0;
                    if (s.idx == `PSN_NVM_IDX_CFG)
                    begin
                        next_s.act_on_onoff_bit =
                            s.nvm[s.idx][`PSN_CFG_ONOFF_BIT];
                        next_s.act_on_pin_switch =
                            s.nvm[s.idx][`PSN_CFG_PIN_BIT];
                    end
                    else
                    begin
                        next_s.user_scratch_bits =
                            s.nvm[s.idx][`PSN_SCRATCH_W-1:0];
                    end
                    next_s.idx = ~s.idx;
                    if (s.idx == `PSN_NVM_IDX_SCR)
                    begin
                        next_s.st   = psn_pkg::NV_IDLE;
                        next_s.busy = 1'b0;
                    end
                end
            end

            default:
            begin
                next_s.st   = psn_pkg::NV_IDLE;
                next_s.busy = 1'b0;
            end
        endcase

        // Supply cycle: the store itself comes back at its factory content
        // here, since this model has no separate non-volatile power domain
        if (!RST_N)
        begin
            next_s                              = '0;
            next_s.st                           = psn_pkg::NV_IDLE;
            next_s.on_off                       = `PSN_RST_ON_OFF;
            next_s.act_on_onoff_bit             = `PSN_RST_ONOFF_BIT;
            next_s.act_on_pin_switch            = `PSN_RST_PIN_BIT;
            next_s.user_scratch_bits            = `PSN_RST_SCRATCH;
            next_s.nvm[`PSN_NVM_IDX_CFG]        =
                pack_cfg(`PSN_RST_ONOFF_BIT, `PSN_RST_PIN_BIT);
            next_s.nvm[`PSN_NVM_IDX_SCR]        =
                pack_scratch(`PSN_RST_SCRATCH);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        s <= next_s;
    end

    // Outputs straight from state flops
    assign RSP_VALID   = s.rsp_valid;
    assign RSP_DATA    = s.rsp_data;
    assign NVM_BUSY    = s.busy;
    assign CONV_ENABLE = s.conv_en;
    assign ALERT_O     = s.alert_lvl;
    assign ALERT_OE    = s.alert;

endmodule

// file: psn_status_nvm_asserts.sv
// Checker of the status block's command answers, copies and alert.
// Assumes it is bound to psn_status_nvm and sees only its ports.
`timescale 1ns/1ps
`include "psn_cfg.svh"
module psn_status_nvm_asserts
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // Command port and answers
    input wire logic        CMD_VALID,
    input wire logic [7:0]  CMD_CODE,
    input wire logic [1:0]  CMD_KIND,
    input wire logic        RSP_VALID,
    input wire logic [15:0] RSP_DATA,
    input wire logic        NVM_BUSY,
    // Alert pin
    input wire logic        ALERT_O,
    input wire logic        ALERT_OE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // A command is taken only while no copy runs
    wire logic tk = CMD_VALID && !NVM_BUSY;
    logic [7:0] last_code;
    // Code seen at the last edge, so an answer can be tied to its read
    always_ff @(posedge MCLK) last_code <= CMD_CODE;
    wire logic rd_full = RSP_VALID && last_code == `PSN_CODE_STAT_FULL;
    a_word_answer: assert property (
        tk && CMD_CODE == `PSN_CODE_STAT_FULL && CMD_KIND == `PSN_KIND_RD_WORD
        |=> RSP_VALID) else $error("status word not answered");
    a_byte_answer: assert property (
        tk && CMD_CODE == `PSN_CODE_STAT_LOW && CMD_KIND == `PSN_KIND_RD_BYTE
        |=> RSP_VALID && RSP_DATA[15:8] == 8'h00) else $error("bad byte read");
    a_unsup_zero: assert property (
        rd_full |-> (RSP_DATA & 16'h1781) == 16'h0000)
        else $error("unsupported status bit set");
    a_store_busy: assert property (
        tk && CMD_CODE == `PSN_CODE_STORE && CMD_KIND == `PSN_KIND_SEND
        |=> NVM_BUSY [*8] ##1 !NVM_BUSY) else $error("store copy length");
    a_restore_busy: assert property (
        tk && CMD_CODE == `PSN_CODE_RESTORE && CMD_KIND == `PSN_KIND_SEND
        |=> NVM_BUSY ##8 !NVM_BUSY) else $error("restore copy length");
    a_busy_refuse: assert property (
        CMD_VALID && NVM_BUSY |=> !RSP_VALID) else $error("answer while busy");
    a_flag_alert: assert property (
        rd_full && (RSP_DATA & 16'hE03E) != 16'h0000 |-> ALERT_OE)
        else $error("flag set without alert");
    a_alert_drive: assert property (
        ALERT_OE |-> ALERT_O == 1'b0) else $error("alert not pulled low");
    a_scratch_mask: assert property (
        RSP_VALID && $past(CMD_CODE) == `PSN_CODE_SCRATCH
        |-> RSP_DATA[15:6] == 10'h000) else $error("scratch top bits set");
endmodule
bind psn_status_nvm psn_status_nvm_asserts chk (.MCLK(MCLK), .RST_N(RST_N),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_KIND(CMD_KIND),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .NVM_BUSY(NVM_BUSY),
    .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));

// file: psn_host_model.sv
// Host model: issues decoded commands and collects read answers.
// Assumes the answer comes one cycle after the taking edge.
`timescale 1ns/1ps
module psn_host_model
(
    // Clock and answers
    input wire logic        MCLK,
    input wire logic        RSP_VALID,
    input wire logic [15:0] RSP_DATA,
    // Command port
    output logic            CMD_VALID,
    output logic [7:0]      CMD_CODE,
    output logic [1:0]      CMD_KIND,
    output logic [7:0]      CMD_WDATA
);
    initial {CMD_VALID, CMD_CODE, CMD_KIND, CMD_WDATA} = 19'h00000;
    // One transfer; FFFF marks no answer. Only one store per run
    task automatic xfer(input logic [7:0] c, input logic [1:0] k,
        input logic [7:0] d, output logic [15:0] r);
        @(posedge MCLK);
        {CMD_VALID, CMD_CODE, CMD_KIND, CMD_WDATA} <= {1'b1, c, k, d};
        @(posedge MCLK);
        // Released fields show no stale value
        {CMD_VALID, CMD_CODE, CMD_WDATA} <= {1'b0, ~c, ~d};
        @(negedge MCLK);
        r = RSP_VALID ? RSP_DATA : 16'hFFFF;
    endtask
endmodule

// file: test_pmbus_status_and_nvm_commands.sv
// Testbench of the status and non-volatile command block.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/1ps
module test_pmbus_status_and_nvm_commands;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  pin = 10'h380;
    logic [15:0] r, rsp_data;
    logic        rsp_valid, nvm_busy, conv_enable, alert_o, alert_oe, cv;
    logic [7:0]  cc, cd;
    logic        mf = 1'b0;
    logic [1:0]  ck;
    int          errors = 0;
    int          tests_run = 0;
    // Rows: code, kind, write data, expected answer
    logic [33:0] rows [13] = '{{8'h79,2'h3,8'h00,16'h0000},
        {8'h78,2'h2,8'h00,16'h0000}, {8'hD0,2'h1,8'hFF,16'hFFFF},
        {8'hD0,2'h2,8'h00,16'h003F}, {8'hD0,2'h1,8'hC5,16'hFFFF},
        {8'hD0,2'h2,8'h00,16'h0005}, {8'h55,2'h0,8'h00,16'hFFFF},
        {8'h78,2'h2,8'h00,16'h0002}, {8'h79,2'h3,8'h00,16'h0002},
        {8'h03,2'h0,8'h00,16'hFFFF}, {8'h78,2'h2,8'h00,16'h0000},
        {8'h79,2'h2,8'h00,16'hFFFF}, {8'h03,2'h0,8'h00,16'hFFFF}};
    always #4 mclk = ~mclk;
    psn_host_model host (.MCLK(mclk), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .CMD_VALID(cv), .CMD_CODE(cc), .CMD_KIND(ck),
        .CMD_WDATA(cd));
    psn_status_nvm dut (.MCLK(mclk), .RST_N(rst_n), .CMD_VALID(cv),
        .CMD_CODE(cc), .CMD_KIND(ck), .CMD_WDATA(cd), .CMD_MALFORMED(mf),
        .ADDR_DONE(1'b1), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .NVM_BUSY(nvm_busy), .OV_FAULT_PIN(pin[0]), .OC_FAULT_PIN(pin[1]),
        .UV_FAULT_PIN(pin[2]), .OT_FAULT_PIN(pin[3]), .VOUT_WARN_PIN(pin[4]),
        .IOUT_WARN_PIN(pin[5]), .VIN_WARN_PIN(pin[6]), .POWER_OK_PIN(pin[7]),
        .OUTPUT_ON_PIN(pin[8]), .ENABLE_PIN(pin[9]),
        .CONV_ENABLE(conv_enable), .ALERT_O(alert_o), .ALERT_OE(alert_oe));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [1:0] k,
        input logic [7:0] d, input logic [15:0] e);
        host.xfer(c, k, d, r);
        chk(r, e);
    endtask
    // Pins change at an edge, then settle past the synchronisers
    task automatic set_pins(input logic [9:0] v);
        @(posedge mclk);
        pin <= v;
        repeat (8) @(negedge mclk);
    endtask
    task automatic conclude;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (rows[i]) rd(rows[i][33:26], rows[i][25:24], rows[i][23:16],
            rows[i][15:0]);
        $display("table done");
        rd(8'hD0, 2'h1, 8'h2A, 16'hFFFF);
        rd(8'h11, 2'h0, 8'h00, 16'hFFFF);
        rd(8'h79, 2'h3, 8'h00, 16'hFFFF);
        repeat (8) @(posedge mclk);
        rd(8'hD0, 2'h1, 8'h11, 16'hFFFF);
        rd(8'h12, 2'h0, 8'h00, 16'hFFFF);
        repeat (10) @(posedge mclk);
        rd(8'hD0, 2'h2, 8'h00, 16'h002A);
        $display("store and restore done");
        set_pins(10'h20F);
        chk({15'h0000, alert_oe}, 16'h0001);
        rd(8'h79, 2'h3, 8'h00, 16'hE87C);
        set_pins(10'h380);
        rd(8'h79, 2'h3, 8'h00, 16'hE03C);
        set_pins(10'h3F0);
        rd(8'h03, 2'h0, 8'h00, 16'hFFFF);
        rd(8'h79, 2'h3, 8'h00, 16'hE000);
        chk({15'h0000, alert_oe}, 16'h0001);
        set_pins(10'h380);
        rd(8'h03, 2'h0, 8'h00, 16'hFFFF);
        rd(8'h79, 2'h3, 8'h00, 16'h0000);
        chk({15'h0000, alert_oe}, 16'h0000);
        @(posedge mclk) mf <= 1'b1;
        @(posedge mclk) mf <= 1'b0;
        rd(8'h78, 2'h2, 8'h00, 16'h0002);
        $display("flags done");
        rd(8'h55, 2'h0, 8'h00, 16'hFFFF);
        set_pins(10'h180);
        chk({15'h0000, conv_enable}, 16'h0000);
        set_pins(10'h380);
        chk({15'h0000, conv_enable}, 16'h0001);
        rd(8'h78, 2'h2, 8'h00, 16'h0000);
        $display("enable cycle done");
        conclude();
    end
    // Watchdog at 25000 cycles, well past the fewer than two hundred cycles the run needs
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
endmodule
